// File: counter_array_defines.svh
// constants for the counter array: register offsets, field positions, reset values, divider counts
`ifndef COUNTER_ARRAY_DEFINES_SVH
`define COUNTER_ARRAY_DEFINES_SVH

// ****************************************
// register offsets
// ****************************************
`define CA_ADDR_MODE 8'hED
`define CA_ADDR_CONTROL 8'hD8
`define CA_ADDR_CYCLE 8'hD9
`define CA_ADDR_MODULE_MODE 8'hDA
`define CA_ADDR_COMPARE 8'hE0

// ****************************************
// field positions
// ****************************************
`define CA_MODE_IDLE_BIT 7
`define CA_MODE_TB_HI 3
`define CA_MODE_TB_LO 1
`define CA_MODE_IRQ_BIT 0
`define CA_MODE_WRITE_MASK 8'h8F
`define CA_CTRL_OVF_BIT 7
`define CA_CTRL_RUN_BIT 6
`define CA_CYC_RELOAD_BIT 7
`define CA_CYC_OVF_BIT 5
`define CA_CYC_LEN_HI 1
`define CA_CYC_LEN_LO 0
`define CA_MM_COMPARE_BIT 6
`define CA_MM_MATCH_BIT 3
`define CA_MM_WIDTH_BIT 1

// ****************************************
// reset values
// ****************************************
`define CA_RESET_BYTE 8'h00
`define CA_RESET_WORD 16'h0000

// ****************************************
// timebase divider counts
// ****************************************
`define CA_DIV12_COUNT 4'hB
`define CA_DIV4_COUNT 2'h3
`define CA_EXT_DIV_COUNT 3'h7

`endif

// File: counter_array_pkg.sv
// types shared by the counter array files
package counter_array_pkg;

    // timebase sources in field order; codes 6 and 7 are reserved
    typedef enum logic [2:0] {
        tb_div12,
        tb_div4,
        tb_timer0,
        tb_ext_edge,
        tb_system_clock,
        tb_ext_div8
    } timebase_t;

    // cycle lengths in field order
    typedef enum logic [1:0] {
        len_8,
        len_9,
        len_10,
        len_11
    } cycle_len_t;

endpackage : counter_array_pkg

// File: width_pwm_channel.sv
// one compare module of the counter array: compare, reload, mode bits and output pin
`timescale 1ns/1ns
`default_nettype none
`include "counter_array_defines.svh"

module width_pwm_channel
    import counter_array_pkg::*;
#(
    parameter int CW = 11
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic tick,
    input wire logic cycle_wrap,
    input wire logic wide_mode,
    input wire logic [CW-1:0] next_low,
    input wire logic [CW-1:0] len_mask,
    input wire logic reload_access_select,
    input wire logic wr_low,
    input wire logic wr_high,
    input wire logic wr_mode,
    input wire logic flag_clear,
    input wire logic [7:0] wdata,
    output logic [15:0] compare_value,
    output logic [15:0] reload_value,
    output logic [7:0] mode_byte,
    output logic module_event_flag,
    output logic module_output_pin
);

    logic comparator_enable, width_mode_enable, match_flag_enable;
    logic next_comparator_enable, next_width_mode_enable, next_match_flag_enable;
    logic [15:0] next_compare_value, next_reload_value;
    logic next_event_flag, next_pin;
    logic active, match;

    // ****************************************
    // next state
    // ****************************************
    assign active = comparator_enable && width_mode_enable && wide_mode; // R6
    assign match = tick && (next_low == (compare_value[CW-1:0] & len_mask)); // R3 R18

    always_comb
    begin
        next_comparator_enable = comparator_enable;
        next_width_mode_enable = width_mode_enable;
        next_match_flag_enable = match_flag_enable;
        next_compare_value = compare_value;
        next_reload_value = reload_value;
        next_event_flag = module_event_flag;
        next_pin = module_output_pin;
        if (wr_mode)
        begin
            next_comparator_enable = wdata[`CA_MM_COMPARE_BIT];
            next_width_mode_enable = wdata[`CA_MM_WIDTH_BIT];
            next_match_flag_enable = wdata[`CA_MM_MATCH_BIT];
        end
        // byte writes steer to reload or compare
        if (wr_low)
        begin
            if (reload_access_select)
                next_reload_value[7:0] = wdata; // R1 R2
            else
                next_compare_value[7:0] = wdata; // R2
            next_comparator_enable = 1'b0; // R9
        end
        if (wr_high)
        begin
            if (reload_access_select)
                next_reload_value[15:8] = wdata; // R1 R2
            else
                next_compare_value[15:8] = wdata; // R2
            next_comparator_enable = 1'b1; // R9
        end
        // wrap first so a zero compare still gives a full high cycle
        if (cycle_wrap && wide_mode)
        begin
            next_pin = 1'b0; // R4 R8
            next_compare_value = reload_value; // R5
        end
        if (active && match)
            next_pin = 1'b1; // R3 R11
        if (!active)
            next_pin = 1'b0; // R12
        // set wins over a software clear in the same cycle
        if (flag_clear)
            next_event_flag = 1'b0;
        if (active && match && match_flag_enable)
            next_event_flag = 1'b1; // R7
    end

    assign mode_byte = {1'b0, comparator_enable, 2'b00, match_flag_enable, 1'b0, width_mode_enable, 1'b0};

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            comparator_enable <= 1'b0;
            width_mode_enable <= 1'b0;
            match_flag_enable <= 1'b0;
            compare_value <= `CA_RESET_WORD;
            reload_value <= `CA_RESET_WORD;
            module_event_flag <= 1'b0;
            module_output_pin <= 1'b0;
        end
        else if (ce)
        begin
            comparator_enable <= next_comparator_enable;
            width_mode_enable <= next_width_mode_enable;
            match_flag_enable <= next_match_flag_enable;
            compare_value <= next_compare_value;
            reload_value <= next_reload_value;
            module_event_flag <= next_event_flag;
            module_output_pin <= next_pin;
        end
    end

endmodule : width_pwm_channel
`default_nettype wire

// File: counter_array_wide_pwm.sv
// counter array top: register port, timebase, free-running counter and wide pwm modules
//
// Summary of operation
// R1 - reload register shares compare byte addresses
// R2 - reload select steers compare byte accesses
// R3 - output rises on low N bits match
// R4 - output falls on overflow out of bit N
// R5 - overflow sets flag, copies reload to compare
// R6 - wide mode needs enables and non-8-bit length
// R7 - match flag enable sets event flag
// R8 - overflow every 512, 1024, 2048 ticks
// R9 - low write clears, high write sets enable
// R10 - software writes low byte before high byte
// R11 - high fraction is (2^N - compare)/2^N
// R12 - comparator disabled keeps output low
// R13 - idle suspend halts counting in idle
// R14 - three-bit field selects counter timebase
// R15 - external input no faster than system_clock/4
// R16 - overflow enable gates interrupt request
// R17 - unused mode bits read zero
// R18 - counter increments per tick, compares low bits
`timescale 1ns/1ns
`default_nettype none
`include "counter_array_defines.svh"

module counter_array_wide_pwm
    import counter_array_pkg::*;
#(
    parameter int NUM_MODULES = 3,
    parameter int CW = 11
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic cpu_idle,
    input wire logic timer0_overflow,
    input wire logic external_count_input,
    input wire logic external_clock,
    output logic irq,
    output logic [NUM_MODULES-1:0] module_output_pin
);

    // ****************************************
    // mode, control and cycle registers
    // ****************************************
    logic idle_suspend, overflow_irq_enable, counter_run, counter_overflow_flag;
    logic reload_access_select, cycle_overflow_flag;
    logic [2:0] timebase_select;
    logic [1:0] cycle_length_select;
    logic next_idle_suspend, next_overflow_irq_enable, next_counter_run, next_counter_overflow_flag;
    logic next_reload_access_select, next_cycle_overflow_flag;
    logic [2:0] next_timebase_select;
    logic [1:0] next_cycle_length_select;
    logic wr_mode_reg, wr_ctrl, wr_cycle;
    logic tick, cycle_wrap, counter_wrap;

    // register write decodes
    assign wr_mode_reg = sfr_wr && (sfr_addr == `CA_ADDR_MODE);
    assign wr_ctrl = sfr_wr && (sfr_addr == `CA_ADDR_CONTROL);
    assign wr_cycle = sfr_wr && (sfr_addr == `CA_ADDR_CYCLE);

    // flags: writing zero clears, hardware set wins the same cycle
    always_comb
    begin
        next_idle_suspend = idle_suspend;
        next_timebase_select = timebase_select;
        next_overflow_irq_enable = overflow_irq_enable;
        next_counter_run = counter_run;
        next_counter_overflow_flag = counter_overflow_flag;
        next_reload_access_select = reload_access_select;
        next_cycle_overflow_flag = cycle_overflow_flag;
        next_cycle_length_select = cycle_length_select;
        if (wr_mode_reg)
        begin
            // bits 6:4 are not stored
            next_idle_suspend = sfr_wdata[`CA_MODE_IDLE_BIT]; // R17
            next_timebase_select = sfr_wdata[`CA_MODE_TB_HI:`CA_MODE_TB_LO];
            next_overflow_irq_enable = sfr_wdata[`CA_MODE_IRQ_BIT];
        end
        if (wr_ctrl)
        begin
            next_counter_run = sfr_wdata[`CA_CTRL_RUN_BIT];
            next_counter_overflow_flag = counter_overflow_flag & sfr_wdata[`CA_CTRL_OVF_BIT];
        end
        if (wr_cycle)
        begin
            next_reload_access_select = sfr_wdata[`CA_CYC_RELOAD_BIT];
            next_cycle_overflow_flag = cycle_overflow_flag & sfr_wdata[`CA_CYC_OVF_BIT];
            next_cycle_length_select = sfr_wdata[`CA_CYC_LEN_HI:`CA_CYC_LEN_LO];
        end
        if (counter_wrap)
            next_counter_overflow_flag = 1'b1;
        if (cycle_wrap)
            next_cycle_overflow_flag = 1'b1; // R5
    end

    // register bank; every flop holds while ce is low
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            idle_suspend <= 1'b0;
            timebase_select <= 3'h0;
            overflow_irq_enable <= 1'b0;
            counter_run <= 1'b0;
            counter_overflow_flag <= 1'b0;
            reload_access_select <= 1'b0;
            cycle_overflow_flag <= 1'b0;
            cycle_length_select <= 2'h0;
        end
        else if (ce)
        begin
            idle_suspend <= next_idle_suspend;
            timebase_select <= next_timebase_select;
            overflow_irq_enable <= next_overflow_irq_enable;
            counter_run <= next_counter_run;
            counter_overflow_flag <= next_counter_overflow_flag;
            reload_access_select <= next_reload_access_select;
            cycle_overflow_flag <= next_cycle_overflow_flag;
            cycle_length_select <= next_cycle_length_select;
        end
    end

    // ****************************************
    // timebase
    // ****************************************
    logic [3:0] div12, next_div12;
    logic [1:0] div4, next_div4;
    logic [2:0] ext_div, next_ext_div;
    logic eci_prev, ext_prev, base_event, suspended;
    logic eci_fall, ext_rise;
    timebase_t tb;

    // edge detects and the idle suspend qualifier
    // after reset a low external count input gives one false falling edge;
    // it only counts if the external edge source is selected
    assign tb = timebase_t'(timebase_select);
    assign eci_fall = eci_prev && !external_count_input; // R15
    assign ext_rise = !ext_prev && external_clock;
    assign suspended = idle_suspend && cpu_idle; // R13

    // prescalers run freely so the first tick after a switch is never late by more than one period
    always_comb
    begin
        next_div12 = (div12 == `CA_DIV12_COUNT) ? 4'h0 : div12 + 4'h1;
        next_div4 = div4 + 2'h1;
        next_ext_div = ext_rise ? ext_div + 3'h1 : ext_div;
        base_event = 1'b0;
        unique case (tb)
            tb_div12: base_event = (div12 == `CA_DIV12_COUNT); // R14
            tb_div4: base_event = (div4 == `CA_DIV4_COUNT); // R14
            tb_timer0: base_event = timer0_overflow; // R14
            tb_ext_edge: base_event = eci_fall; // R14
            tb_system_clock: base_event = 1'b1; // R14
            tb_ext_div8: base_event = ext_rise && (ext_div == `CA_EXT_DIV_COUNT); // R14
            default: base_event = 1'b0; // reserved codes do not count
        endcase
    end

    // run control and idle gate every counted event
    assign tick = base_event && counter_run && !suspended; // R13

    // prescalers and edge history, frozen with ce
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            div12 <= 4'h0;
            div4 <= 2'h0;
            ext_div <= 3'h0;
            eci_prev <= 1'b1;
            ext_prev <= 1'b0;
        end
        else if (ce)
        begin
            div12 <= next_div12;
            div4 <= next_div4;
            ext_div <= next_ext_div;
            eci_prev <= external_count_input;
            ext_prev <= external_clock;
        end
    end

    // ****************************************
    // counter and cycle wrap
    // ****************************************
    logic [15:0] counter_value, next_counter_value;
    logic [CW-1:0] len_mask, next_low;
    logic wide_mode;

    // mask of the N counted bits for the selected length
    always_comb
    begin
        unique case (cycle_length_select)
            len_8: len_mask = 11'h0FF;
            len_9: len_mask = 11'h1FF;
            len_10: len_mask = 11'h3FF;
            len_11: len_mask = 11'h7FF;
        endcase
    end

    // wrap is decoded from the value before the tick,
    // so pins fall on the same edge the low bits roll to zero
    assign wide_mode = (cycle_length_select != len_8); // R6
    assign next_counter_value = tick ? counter_value + 16'h0001 : counter_value; // R18
    assign next_low = next_counter_value[CW-1:0] & len_mask; // R18
    assign cycle_wrap = tick && wide_mode && ((counter_value[CW-1:0] & len_mask) == len_mask); // R4 R8
    assign counter_wrap = tick && (counter_value == 16'hFFFF);

    // full 16-bit count; the modules see only the low N bits
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            counter_value <= `CA_RESET_WORD;
        else if (ce)
            counter_value <= next_counter_value;
    end

    // ****************************************
    // compare modules
    // ****************************************
    logic [15:0] mod_compare [NUM_MODULES];
    logic [15:0] mod_reload [NUM_MODULES];
    logic [7:0] mod_mode [NUM_MODULES];
    logic [NUM_MODULES-1:0] mod_flag;

    // one instance per module, each decoding its own byte addresses;
    // compare bits above N are ignored by the match
    for (genvar i = 0; i < NUM_MODULES; i++)
    begin : g_mod
        width_pwm_channel #(.CW(CW)) u_channel (
            .clk(clk),
            .reset(reset),
            .ce(ce),
            .tick(tick),
            .cycle_wrap(cycle_wrap),
            .wide_mode(wide_mode),
            .next_low(next_low),
            .len_mask(len_mask),
            .reload_access_select(reload_access_select),
            .wr_low(sfr_wr && (sfr_addr == `CA_ADDR_COMPARE + 8'(2 * i))),
            .wr_high(sfr_wr && (sfr_addr == `CA_ADDR_COMPARE + 8'(2 * i + 1))),
            .wr_mode(sfr_wr && (sfr_addr == `CA_ADDR_MODULE_MODE + 8'(i))),
            .flag_clear(wr_ctrl && !sfr_wdata[i]),
            .wdata(sfr_wdata),
            .compare_value(mod_compare[i]),
            .reload_value(mod_reload[i]),
            .mode_byte(mod_mode[i]),
            .module_event_flag(mod_flag[i]),
            .module_output_pin(module_output_pin[i])
        );
    end

    // ****************************************
    // read port and interrupt
    // ****************************************
    logic [7:0] next_rdata;
    logic [15:0] sel_word;

    // read mux; unmapped addresses read as zero
    always_comb
    begin
        next_rdata = `CA_RESET_BYTE;
        sel_word = `CA_RESET_WORD;
        if (sfr_addr == `CA_ADDR_MODE)
            next_rdata = {idle_suspend, 3'b000, timebase_select, overflow_irq_enable}; // R17
        else if (sfr_addr == `CA_ADDR_CONTROL)
            next_rdata = {counter_overflow_flag, counter_run, 6'(mod_flag)};
        else if (sfr_addr == `CA_ADDR_CYCLE)
            next_rdata = {reload_access_select, 1'b0, cycle_overflow_flag, 3'b000, cycle_length_select};
        for (int i = 0; i < NUM_MODULES; i++)
        begin
            sel_word = reload_access_select ? mod_reload[i] : mod_compare[i]; // R2
            if (sfr_addr == `CA_ADDR_MODULE_MODE + 8'(i))
                next_rdata = mod_mode[i] | {7'h00, mod_flag[i]};
            if (sfr_addr == `CA_ADDR_COMPARE + 8'(2 * i))
                next_rdata = sel_word[7:0];
            if (sfr_addr == `CA_ADDR_COMPARE + 8'(2 * i + 1))
                next_rdata = sel_word[15:8];
        end
    end

    // read data holds until the next read strobe;
    // irq trails its flag by one cycle to keep the output registered
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sfr_rdata <= `CA_RESET_BYTE;
            irq <= 1'b0;
        end
        else if (ce)
        begin
            if (sfr_rd)
                sfr_rdata <= next_rdata;
            irq <= overflow_irq_enable && counter_overflow_flag; // R16
        end
    end

endmodule : counter_array_wide_pwm
`default_nettype wire

// File: counter_array_wide_pwm_chk.sv
// port checker for the counter array, with its bind
`timescale 1ns/1ns
`default_nettype none

module counter_array_wide_pwm_chk
    import counter_array_pkg::*;
#(
    parameter int NUM_MODULES = 3,
    parameter int CW = 11
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic cpu_idle,
    input wire logic timer0_overflow,
    input wire logic external_count_input,
    input wire logic external_clock,
    input wire logic irq,
    input wire logic [NUM_MODULES-1:0] module_output_pin
);
    logic [7:0] mode;
    logic [2:0] still;

    // mode shadow; still counts quiet cycles so pipelined ticks settle first
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            mode <= 8'h00;
            still <= 3'h0;
        end
        else
        begin
            if (ce && sfr_wr && sfr_addr == 8'hED)
                mode <= sfr_wdata & 8'h8F;
            still <= sfr_wr ? 3'h0 : (still == 3'h4 ? still : still + 3'h1);
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // ****************************************
    // port relations
    // ****************************************
    property p_mode_rb; ce && sfr_rd && sfr_addr == 8'hED |=> sfr_rdata == $past(mode); endproperty
    a_mode_rb: assert property (p_mode_rb) else $error("mode readback wrong");
    property p_low_clr; ce && sfr_wr && sfr_addr == 8'hE0 ##1 ce && sfr_rd && sfr_addr == 8'hDA |=> !sfr_rdata[6]; endproperty
    a_low_clr: assert property (p_low_clr) else $error("low write kept enable");
    property p_high_set; ce && sfr_wr && sfr_addr == 8'hE1 ##1 ce && sfr_rd && sfr_addr == 8'hDA |=> sfr_rdata[6]; endproperty
    a_high_set: assert property (p_high_set) else $error("high write left enable clear");
    property p_dis; ce && sfr_wr && sfr_addr == 8'hDA && !(sfr_wdata[6] && sfr_wdata[1]) ##1 ce && !sfr_wr
        |=> !module_output_pin[0]; endproperty
    a_dis: assert property (p_dis) else $error("disabled module drove high");
    property p_len8; ce && sfr_wr && sfr_addr == 8'hD9 && sfr_wdata[1:0] == 2'h0 ##1 ce && !sfr_wr
        |=> module_output_pin == '0; endproperty
    a_len8: assert property (p_len8) else $error("eight bit length drove high");
    property p_rsv; still == 3'h4 && mode[3:2] == 2'h3 |-> $stable(module_output_pin); endproperty
    a_rsv: assert property (p_rsv) else $error("reserved timebase ticked");
    property p_idle; still == 3'h4 && mode[7] && cpu_idle && $past(cpu_idle, 2) |-> $stable(module_output_pin); endproperty
    a_idle: assert property (p_idle) else $error("pin moved while suspended");
    property p_irq; still == 3'h4 && !mode[0] |-> !irq; endproperty
    a_irq: assert property (p_irq) else $error("masked request seen");
endmodule : counter_array_wide_pwm_chk

bind counter_array_wide_pwm counter_array_wide_pwm_chk #(.NUM_MODULES(NUM_MODULES), .CW(CW)) chk_i (
    .clk, .reset, .ce, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .cpu_idle,
    .timer0_overflow, .external_count_input, .external_clock, .irq, .module_output_pin);

`default_nettype wire

// File: tb_top.sv
// self-checking bench for the counter array
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    import counter_array_pkg::*;
    logic clk, reset, ce, sfr_wr, sfr_rd, cpu_idle, irq, rd_d, p_d;
    logic timer0_overflow, external_count_input, external_clock;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [2:0] module_output_pin;
    logic [15:0] lf, v, eh[$], ep[$];
    logic [7:0] eq[$];
    int bad_count, cmp_count, cyc, hi, per, k;
    int m[6] = '{12, 4, 2, 8, 1, 32};

    counter_array_wide_pwm dut (.clk, .reset, .ce, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
        .cpu_idle, .timer0_overflow, .external_count_input, .external_clock, .irq, .module_output_pin);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [15:0] nx(input logic [15:0] s);
        nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nx

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e)
        begin
            bad_count++;
            $display("FAIL %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk

    task automatic final_report();
        bad_count += eq.size() + eh.size(); // notes never judged
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    // bus cycles hold their strobe; nop releases it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} <= {2'h2, a, d};
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        {sfr_wr, sfr_rd, sfr_addr} <= {2'h1, a};
        eq.push_back(e);
        @(posedge clk);
    endtask : rd

    task automatic nop();
        {sfr_wr, sfr_rd} <= 2'h0;
        @(posedge clk);
    endtask : nop

    task automatic wf();
        int i;
        i = 0;
        do
        begin
            @(posedge clk);
            i++;
        end
        while (!(p_d && !module_output_pin[0]) && i < 40000);
        if (i >= 40000)
            bad_count++;
    endtask : wf

    // arm after a fall so the monitor only judges whole cycles
    task automatic meas(input logic [15:0] h, input logic [15:0] p);
        wf();
        @(negedge clk);
        eh.push_back(h);
        ep.push_back(p);
        wf();
    endtask : meas

    // reload first, then compare, each low byte before high
    task automatic setcmp(input int n, input logic [15:0] c);
        for (int a = 1; a >= 0; a--)
        begin
            wr(8'hD9, {1'(a), 5'h00, 2'(n)});
            wr(8'hE0, c[7:0]);
            wr(8'hE1, c[15:8]);
        end
        nop();
    endtask : setcmp

    // sel high counts high cycles, low counts pin changes
    task automatic quiet(input logic sel);
        k = 0;
        repeat (4) @(posedge clk);
        repeat (2100)
        begin
            @(posedge clk);
            k += sel ? int'(module_output_pin[0]) : int'(module_output_pin[0] !== p_d);
            k += int'(module_output_pin[2:1] !== 2'b00);
        end
        chk(16'(k), 16'h0000);
    endtask : quiet

    // 250 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // external timebases and the run ceiling
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        timer0_overflow <= cyc[0];
        external_count_input <= cyc[2];
        external_clock <= cyc[1];
        if (cyc == 99000)
        begin
            bad_count++;
            final_report();
        end
    end

    // scoreboard: read data and pwm segment lengths against queued notes
    always @(posedge clk)
    begin
        rd_d <= sfr_rd;
        p_d <= module_output_pin[0];
        hi <= hi + int'(module_output_pin[0]);
        per <= per + 1;
        if (rd_d && eq.size() > 0)
            chk({8'h00, sfr_rdata}, {8'h00, eq.pop_front()});
        if (p_d && !module_output_pin[0])
        begin
            if (eh.size() > 0)
            begin
                chk(16'(hi), eh.pop_front());
                chk(16'(per), ep.pop_front());
            end
            hi <= 0;
            per <= 1;
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        reset = 1'b1;
        ce = 1'b1;
        {sfr_wr, sfr_rd, cpu_idle} = 3'h0;
        {sfr_addr, sfr_wdata} = 16'h0000;
        lf = 16'h0375; // seed 885
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(8'hED, 8'h00);
        rd(8'hD9, 8'h00);
        rd(8'h00, 8'h00);
        repeat (4)
        begin
            lf = nx(lf);
            wr(8'hED, lf[7:0]);
            rd(8'hED, lf[7:0] & 8'h8F);
        end
        wr(8'hDA, 8'h02);
        rd(8'hDA, 8'h02);
        wr(8'hE1, 8'h00);
        rd(8'hDA, 8'h42);
        wr(8'hE0, 8'h00);
        rd(8'hDA, 8'h02);
        lf = nx(lf);
        wr(8'hD9, 8'h80);
        rd(8'hD9, 8'h80);
        wr(8'hE0, lf[7:0]);
        wr(8'hE1, {5'h00, lf[10:8]});
        rd(8'hE0, lf[7:0]);
        rd(8'hE1, {5'h00, lf[10:8]});
        wr(8'hD9, 8'h00);
        rd(8'hE0, 8'h00);
        rd(8'hE1, 8'h00);
        nop();
        $display("test registers done");
        wr(8'hED, 8'h08);
        wr(8'hDA, 8'h42);
        wr(8'hD8, 8'h40);
        for (int n = 1; n < 4; n++)
        begin
            lf = nx(lf);
            v = (lf & ((16'h0100 << n) - 16'h0001)) | 16'h0001;
            setcmp(n, v);
            meas((16'h0100 << n) - v, 16'h0100 << n);
        end
        wr(8'hD9, 8'h83);
        wr(8'hE0, 8'h10);
        wr(8'hE1, 8'h00);
        wr(8'hD9, 8'h03);
        nop();
        meas(16'h07F0, 16'h0800);
        rd(8'hD9, 8'h23);
        wr(8'hDA, 8'h4A);
        nop();
        wf();
        wf();
        rd(8'hD8, 8'h41);
        rd(8'hDA, 8'h4B);
        nop();
        $display("test wide pwm done");
        wr(8'hE0, 8'h10);
        rd(8'hDA, 8'h0B);
        wr(8'hD8, 8'h40);
        rd(8'hDA, 8'h0A);
        nop();
        quiet(1'b1);
        wr(8'hE1, 8'h00);
        wr(8'hED, 8'h88);
        cpu_idle <= 1'b1;
        nop();
        quiet(1'b0);
        wr(8'hED, 8'h08);
        nop();
        meas(16'h07F0, 16'h0800);
        cpu_idle <= 1'b0;
        $display("test disable and idle done");
        for (int c = 6; c < 8; c++)
        begin
            wr(8'hED, 8'(c << 1));
            nop();
            quiet(1'b0);
        end
        setcmp(1, 16'h0010);
        for (int c = 0; c < 6; c++)
        begin
            wr(8'hED, 8'(c << 1));
            nop();
            meas(16'(496 * m[c]), 16'(512 * m[c]));
        end
        wr(8'hED, 8'h09);
        nop();
        nop();
        chk({15'h0000, irq}, 16'h0000);
        $display("test timebases done");
        final_report();
    end
endmodule : tb_top

`default_nettype wire
